// file: io_port_pin_control.sv
/*
 what: apb register front end for three 4-bit ports, band oscillator
 input control and the two charge pump output drivers.
 assumes: presetn is the power-on reset; watchdog_stack_reset and clock_stop
 come from pclk logic; ce_reset and the port pins come from outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "io_port_defs.svh"

module io_port_pin_control #(
   parameter int W = `PORT_W
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`APB_ADDR_W-1:0] paddr,
   input wire logic [`APB_DATA_W-1:0] pwdata,
   output logic [`APB_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // reset sources and clock stop
   input wire logic watchdog_stack_reset,
   input wire logic ce_reset,
   input wire logic clock_stop,
   // port one-d
   input wire logic [W-1:0] port_one_d_pins_in,
   output logic [W-1:0] port_one_d_pins_out,
   output logic [W-1:0] port_one_d_pins_oe,
   // port two-b
   input wire logic [W-1:0] port_two_b_pins_in,
   output logic [W-1:0] port_two_b_pins_out,
   output logic [W-1:0] port_two_b_pins_oe,
   // port three-c
   input wire logic [W-1:0] port_three_c_pins_in,
   output logic [W-1:0] port_three_c_pins_out,
   output logic [W-1:0] port_three_c_pins_oe,
   // band oscillator inputs
   output logic high_band_osc_input_en,
   output logic high_band_osc_input_pulldown,
   output logic low_band_osc_input_en,
   output logic low_band_osc_input_pulldown,
   // charge pump outputs
   output logic charge_pump_out_zero_out,
   output logic charge_pump_out_zero_oe,
   output logic charge_pump_out_one_out,
   output logic charge_pump_out_one_oe
);

   ////////////////////////////////////////////////////////////////////////
   // declarations

   port_ctl_if pc [`PORT_COUNT] ();

   logic [`PORT_COUNT-1:0][W-1:0] pins_in;
   logic [`PORT_COUNT-1:0][W-1:0] pin_state;
   logic [`PORT_COUNT-1:0][W-1:0] drv_out;
   logic [`PORT_COUNT-1:0][W-1:0] drv_oe;

   io_port_pkg::band_e band_r;
   logic [`CP_CTL_W-1:0] cp_ctl_r;
   logic [2:0] flags_r;
   logic [2:0] flags_nxt;
   logic ce_meta_r;
   logic ce_sync_r;
   logic stop_r;
   logic [`APB_DATA_W-1:0] prdata_r;
   logic [`APB_DATA_W-1:0] prdata_nxt;
   logic pready_r;
   logic pslverr_r;
   logic pslverr_nxt;
   logic setup;
   logic wr_en;
   logic any_reset;
   logic hi_en_r;
   logic lo_en_r;
   logic hi_pd_r;
   logic lo_pd_r;
   logic cp0_oe_r;
   logic cp1_oe_r;
   logic cp0_out_r;
   logic cp1_out_r;

   assign pins_in[0] = port_one_d_pins_in;
   assign pins_in[1] = port_two_b_pins_in;
   assign pins_in[2] = port_three_c_pins_in;

   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready_r && pwrite;
   assign any_reset = watchdog_stack_reset || ce_sync_r;

   ////////////////////////////////////////////////////////////////////////
   // address decode helpers

   function automatic logic port_hit(
      input logic [`APB_ADDR_W-1:0] a,
      input int idx,
      input logic [`APB_ADDR_W-1:0] sub
   );
      logic [`APB_ADDR_W-1:0] base;
      base = `OFF_PORT_BASE + `OFF_PORT_STRIDE * idx[`APB_ADDR_W-1:0];
      port_hit = (a == base + sub);
   endfunction

   function automatic logic [`APB_DATA_W-1:0] nib(input logic [W-1:0] v);
      nib = {{(`APB_DATA_W-W){1'b0}}, v};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // ports

   genvar gi;
   generate
      for (gi = 0; gi < `PORT_COUNT; gi++) begin : g_port
         assign pc[gi].wr_dir = wr_en && port_hit(paddr, gi, `SUB_DIR);
         assign pc[gi].wr_out = wr_en && port_hit(paddr, gi, `SUB_OUT);
         assign pc[gi].wdata = pwdata[W-1:0];
         // ce reset deliberately absent: pins keep their state
         assign pc[gi].soft_clr = watchdog_stack_reset;
         assign pin_state[gi] = pc[gi].pins;
         assign drv_out[gi] = pc[gi].out;
         assign drv_oe[gi] = pc[gi].dir;

         io_port_cell #(
            .W(W),
            .PER_BIT(gi != 2)
         ) u_port (
            .pclk(pclk),
            .presetn(presetn),
            .pc(pc[gi]),
            .pin_in(pins_in[gi])
         );
      end
   endgenerate

   assign port_one_d_pins_out = drv_out[0];
   assign port_one_d_pins_oe = drv_oe[0];
   assign port_two_b_pins_out = drv_out[1];
   assign port_two_b_pins_oe = drv_oe[1];
   assign port_three_c_pins_out = drv_out[2];
   assign port_three_c_pins_oe = drv_oe[2];

   ////////////////////////////////////////////////////////////////////////
   // ce reset pin synchroniser, stop level

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ce_meta_r <= 1'b0;
         ce_sync_r <= 1'b0;
      end else begin
         ce_meta_r <= ce_reset;
         ce_sync_r <= ce_meta_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_r <= 1'b0;
      end else begin
         stop_r <= clock_stop;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // band mode

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         band_r <= io_port_pkg::BAND_NONE;
      end else if (watchdog_stack_reset) begin
         band_r <= io_port_pkg::BAND_NONE;
      end else if (wr_en && paddr == `OFF_BAND) begin
         band_r <= io_port_pkg::band_e'(pwdata[`BAND_MSB:`BAND_LSB]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_en_r <= 1'b0;
         lo_en_r <= 1'b0;
         hi_pd_r <= 1'b1;
         lo_pd_r <= 1'b1;
      end else begin
         hi_en_r <= (band_r == io_port_pkg::BAND_VHF);
         lo_en_r <= (band_r == io_port_pkg::BAND_HF) ||
                    (band_r == io_port_pkg::BAND_MW);
         hi_pd_r <= (band_r != io_port_pkg::BAND_VHF);
         lo_pd_r <= (band_r != io_port_pkg::BAND_HF) &&
                    (band_r != io_port_pkg::BAND_MW);
      end
   end

   assign high_band_osc_input_en = hi_en_r;
   assign high_band_osc_input_pulldown = hi_pd_r;
   assign low_band_osc_input_en = lo_en_r;
   assign low_band_osc_input_pulldown = lo_pd_r;

   ////////////////////////////////////////////////////////////////////////
   // charge pump control

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cp_ctl_r <= `RST_CP_CTL;
      end else if (any_reset) begin
         cp_ctl_r <= `RST_CP_CTL;
      end else if (wr_en && paddr == `OFF_CP_CTL) begin
         cp_ctl_r <= pwdata[`CP_CTL_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cp0_oe_r <= 1'b0;
         cp1_oe_r <= 1'b0;
         cp0_out_r <= 1'b0;
         cp1_out_r <= 1'b0;
      end else begin
         // released drivers float while stopped or in any reset
         cp0_oe_r <= cp_ctl_r[`CP_EN0_BIT] && !clock_stop && !any_reset;
         cp1_oe_r <= cp_ctl_r[`CP_EN1_BIT] && !clock_stop && !any_reset;
         cp0_out_r <= cp_ctl_r[`CP_VAL0_BIT];
         cp1_out_r <= cp_ctl_r[`CP_VAL1_BIT];
      end
   end

   assign charge_pump_out_zero_oe = cp0_oe_r;
   assign charge_pump_out_one_oe = cp1_oe_r;
   assign charge_pump_out_zero_out = cp0_out_r;
   assign charge_pump_out_one_out = cp1_out_r;

   ////////////////////////////////////////////////////////////////////////
   // reset cause flags, write one to clear, set wins

   always_comb begin
      flags_nxt = flags_r;
      if (wr_en && paddr == `OFF_STATUS) begin
         flags_nxt = flags_r & ~pwdata[`ST_CE_BIT:`ST_POR_BIT];
      end
      if (watchdog_stack_reset) begin
         flags_nxt[`ST_WDT_BIT] = 1'b1;
      end
      if (ce_sync_r) begin
         flags_nxt[`ST_CE_BIT] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_r <= `RST_FLAGS;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux, captured in the setup cycle

   always_comb begin
      prdata_nxt = `RST_WORD;
      pslverr_nxt = 1'b0;
      if (paddr == `OFF_BAND) begin
         prdata_nxt = {{(`APB_DATA_W-2){1'b0}}, band_r};
      end else if (port_hit(paddr, 0, `SUB_DIR)) begin
         prdata_nxt = nib(pc[0].dir);
      end else if (port_hit(paddr, 0, `SUB_OUT)) begin
         prdata_nxt = nib(pc[0].out);
      end else if (port_hit(paddr, 0, `SUB_PIN)) begin
         prdata_nxt = nib(pin_state[0]);
      end else if (port_hit(paddr, 1, `SUB_DIR)) begin
         prdata_nxt = nib(pc[1].dir);
      end else if (port_hit(paddr, 1, `SUB_OUT)) begin
         prdata_nxt = nib(pc[1].out);
      end else if (port_hit(paddr, 1, `SUB_PIN)) begin
         prdata_nxt = nib(pin_state[1]);
      end else if (port_hit(paddr, 2, `SUB_DIR)) begin
         prdata_nxt = nib(pc[2].dir);
      end else if (port_hit(paddr, 2, `SUB_OUT)) begin
         prdata_nxt = nib(pc[2].out);
      end else if (port_hit(paddr, 2, `SUB_PIN)) begin
         prdata_nxt = nib(pin_state[2]);
      end else if (paddr == `OFF_CP_CTL) begin
         prdata_nxt = {{(`APB_DATA_W-`CP_CTL_W){1'b0}}, cp_ctl_r};
      end else if (paddr == `OFF_STATUS) begin
         prdata_nxt = {{(`APB_DATA_W-`ST_W){1'b0}}, stop_r, flags_r};
      end else begin
         pslverr_nxt = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb answer: ready in the first access cycle

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= `RST_WORD;
      end else begin
         pready_r <= setup;
         if (setup) begin
            pslverr_r <= pslverr_nxt;
            prdata_r <= pwrite ? `RST_WORD : prdata_nxt;
         end else begin
            pslverr_r <= 1'b0;
            prdata_r <= `RST_WORD;
         end
      end
   end

   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prdata = prdata_r;

endmodule // io_port_pin_control

`default_nettype wire

// file: io_port_defs.svh
/*
 what: offsets, field positions, reset values and widths for the pin control block.
 assumes: included by bare name; byte addresses on a 32-bit apb word bus.
*/
`ifndef IO_PORT_DEFS_SVH
`define IO_PORT_DEFS_SVH

// bus geometry
`define APB_ADDR_W 8
`define APB_DATA_W 32
`define PORT_W 4
`define PORT_COUNT 3

// register byte offsets
`define OFF_BAND 8'h00
`define OFF_PORT_BASE 8'h04
`define OFF_PORT_STRIDE 8'h0c
`define SUB_DIR 8'h00
`define SUB_OUT 8'h04
`define SUB_PIN 8'h08
`define OFF_CP_CTL 8'h28
`define OFF_STATUS 8'h2c

// band register field
`define BAND_LSB 0
`define BAND_MSB 1

// charge pump control fields
`define CP_EN0_BIT 0
`define CP_EN1_BIT 1
`define CP_VAL0_BIT 2
`define CP_VAL1_BIT 3
`define CP_CTL_W 4

// status fields
`define ST_POR_BIT 0
`define ST_WDT_BIT 1
`define ST_CE_BIT 2
`define ST_STOP_BIT 3
`define ST_W 4

// reset values
`define RST_NIBBLE 4'h0
`define RST_CP_CTL 4'h0
`define RST_FLAGS 3'b001
`define RST_WORD 32'h0000_0000

`endif

// file: io_port_pkg.sv
/*
 what: shared types of the pin control block.
 assumes: used by scoped name only, never imported.
*/
`default_nettype none

package io_port_pkg;
   // band selection written by software
   typedef enum logic [1:0] {
      BAND_NONE,
      BAND_VHF,
      BAND_HF,
      BAND_MW
   } band_e;
endpackage

`default_nettype wire

// file: port_ctl_if.sv
/*
 what: carrier between the register logic and one 4-bit port.
 assumes: both ends run on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "io_port_defs.svh"

interface port_ctl_if;
   logic wr_dir;
   logic wr_out;
   logic soft_clr;
   logic [`PORT_W-1:0] wdata;
   logic [`PORT_W-1:0] dir;
   logic [`PORT_W-1:0] out;
   logic [`PORT_W-1:0] pins;

   modport ctl (
      output wr_dir,
      output wr_out,
      output soft_clr,
      output wdata,
      input dir,
      input out,
      input pins
   );

   modport port (
      input wr_dir,
      input wr_out,
      input soft_clr,
      input wdata,
      output dir,
      output out,
      output pins
   );
endinterface

`default_nettype wire

// file: io_port_cell.sv
/*
 what: one 4-bit i/o port: direction, output latch and pin input synchroniser.
 assumes: pin inputs come from outside pclk; strobes come from pclk logic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "io_port_defs.svh"

module io_port_cell #(
   parameter int W = `PORT_W,
   parameter bit PER_BIT = 1'b1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control side
   port_ctl_if.port pc,
   // pin side
   input wire logic [W-1:0] pin_in
);

   logic [W-1:0] dir_r;
   logic [W-1:0] out_r;
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;

   ////////////////////////////////////////////////////////////////////////
   // direction: 1 drives the pin

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_r <= `RST_NIBBLE;
      end else if (pc.soft_clr) begin
         dir_r <= `RST_NIBBLE;
      end else if (pc.wr_dir) begin
         if (PER_BIT) begin
            dir_r <= pc.wdata;
         end else begin
            dir_r <= {W{pc.wdata[0]}};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output latch, written whatever the direction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_r <= `RST_NIBBLE;
      end else if (pc.wr_out) begin
         out_r <= pc.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // two-stage pin synchroniser

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= `RST_NIBBLE;
         sync_r <= `RST_NIBBLE;
      end else begin
         meta_r <= pin_in;
         sync_r <= meta_r;
      end
   end

   assign pc.dir = dir_r;
   assign pc.out = out_r;
   assign pc.pins = sync_r;

endmodule // io_port_cell

`default_nettype wire

// file: board_pins.sv
/*
 what: board side of one 4-bit port, the level each pin settles to.
 assumes: device oe/out come from pclk logic; board drive comes from the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module board_pins (
   // device side
   input wire logic [3:0] oe,
   input wire logic [3:0] out,
   // board side
   input wire logic [3:0] drv,
   output logic [3:0] level
);
   // a driving device bit overrides the weak board source
   always_comb level = (oe & out) | (~oe & drv);
endmodule // board_pins

`default_nettype wire

// file: io_port_checker.sv
/*
 what: port-level assertions for the pin control block.
 assumes: bound to io_port_pin_control; one clock domain, presetn low active.
*/
`timescale 1ns/1ps
`default_nettype none

module io_port_checker #(
   parameter int W = 4
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // reset sources and clock stop
   input wire logic watchdog_stack_reset,
   input wire logic ce_reset,
   input wire logic clock_stop,
   // ports
   input wire logic [W-1:0] port_one_d_pins_oe,
   input wire logic [W-1:0] port_two_b_pins_oe,
   input wire logic [W-1:0] port_three_c_pins_oe,
   // oscillator and charge pump
   input wire logic high_band_osc_input_en,
   input wire logic high_band_osc_input_pulldown,
   input wire logic low_band_osc_input_en,
   input wire logic low_band_osc_input_pulldown,
   input wire logic charge_pump_out_zero_oe,
   input wire logic charge_pump_out_one_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_ce_held;
      ce_reset [*4];
   endsequence
   sequence s_cp_off;
      !charge_pump_out_zero_oe && !charge_pump_out_one_oe;
   endsequence

   property p_answer;
      s_setup |=> pready;
   endproperty
   property p_hb;
      high_band_osc_input_en != high_band_osc_input_pulldown;
   endproperty
   property p_lb;
      low_band_osc_input_en != low_band_osc_input_pulldown;
   endproperty
   property p_one_band;
      !(high_band_osc_input_en && low_band_osc_input_en);
   endproperty
   property p_nibble;
      (&port_three_c_pins_oe) || !(|port_three_c_pins_oe);
   endproperty
   property p_wd_ports;
      watchdog_stack_reset |=> !(|{port_one_d_pins_oe, port_two_b_pins_oe,
         port_three_c_pins_oe});
   endproperty
   property p_wd_cp;
      watchdog_stack_reset |-> ##2 s_cp_off;
   endproperty
   property p_stop_cp;
      clock_stop |=> s_cp_off;
   endproperty
   property p_ce_cp;
      s_ce_held |-> s_cp_off;
   endproperty
   property p_ce_hold;
      ce_reset && !psel && !watchdog_stack_reset |=>
         $stable({port_one_d_pins_oe, port_two_b_pins_oe, port_three_c_pins_oe});
   endproperty

   a_answer: assert property (p_answer) else $error("no answer after setup");
   a_hb: assert property (p_hb) else $error("high band enable and pulldown agree");
   a_lb: assert property (p_lb) else $error("low band enable and pulldown agree");
   a_one_band: assert property (p_one_band) else $error("both bands on");
   a_nibble: assert property (p_nibble) else $error("port three-c split");
   a_wd_ports: assert property (p_wd_ports) else $error("port still output");
   a_wd_cp: assert property (p_wd_cp) else $error("pump driven after reset");
   a_stop_cp: assert property (p_stop_cp) else $error("pump driven in stop");
   a_ce_cp: assert property (p_ce_cp) else $error("pump driven after ce");
   a_ce_hold: assert property (p_ce_hold) else $error("ce moved a port");
endmodule // io_port_checker

bind io_port_pin_control io_port_checker #(.W(W)) i_chk (
   .pclk, .presetn, .psel, .penable, .pready, .watchdog_stack_reset, .ce_reset,
   .clock_stop, .port_one_d_pins_oe, .port_two_b_pins_oe, .port_three_c_pins_oe,
   .high_band_osc_input_en, .high_band_osc_input_pulldown, .low_band_osc_input_en,
   .low_band_osc_input_pulldown, .charge_pump_out_zero_oe, .charge_pump_out_one_oe
);

`default_nettype wire

// file: io_port_pin_control_tb.sv
/*
 what: bench for io_port_pin_control: apb master, board pins, reference model.
 assumes: header, package, design, board model and checker compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module io_port_pin_control_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic wd, ce, stp, hb_en, hb_pd, lb_en, lb_pd, cp0, cp0_oe, cp1, cp1_oe;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [2:0][3:0] po, oe, pin, drv;
   int miscompares = 0, checks = 0, cyc = 0, seed, band_m, cp_m, stop_m;
   int dir_m[3], out_m[3];

   io_port_pin_control i_dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .watchdog_stack_reset(wd), .ce_reset(ce), .clock_stop(stp),
      .port_one_d_pins_in(pin[0]), .port_one_d_pins_out(po[0]),
      .port_one_d_pins_oe(oe[0]), .port_two_b_pins_in(pin[1]),
      .port_two_b_pins_out(po[1]), .port_two_b_pins_oe(oe[1]),
      .port_three_c_pins_in(pin[2]), .port_three_c_pins_out(po[2]),
      .port_three_c_pins_oe(oe[2]), .high_band_osc_input_en(hb_en),
      .high_band_osc_input_pulldown(hb_pd), .low_band_osc_input_en(lb_en),
      .low_band_osc_input_pulldown(lb_pd), .charge_pump_out_zero_out(cp0),
      .charge_pump_out_zero_oe(cp0_oe), .charge_pump_out_one_out(cp1),
      .charge_pump_out_one_oe(cp1_oe)
   );
   for (genvar g = 0; g < 3; g++) begin : g_board
      board_pins i_board (.oe(oe[g]), .out(po[g]), .drv(drv[g]), .level(pin[g]));
   end

   ////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares = miscompares + 1;
         conclude();
      end
   end

   ////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checks = checks + 1;
      if (s !== x) begin
         miscompares = miscompares + 1;
         $display("BAD %0t seen %h expected %h", $time, s, x);
      end
   endtask
   // one transfer, entered just after an edge, one idle cycle after
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r, x);
   endtask
   // waits three edges, then compares every pin-side output with the model
   task automatic outs();
      repeat (3) @(posedge pclk);
      for (int p = 0; p < 3; p++) begin
         chk(oe[p], dir_m[p]);
         chk(po[p], out_m[p]);
      end
      chk({hb_en, hb_pd, lb_en, lb_pd}, {band_m == 1, band_m != 1, band_m > 1, band_m < 2});
      chk({cp1_oe, cp0_oe}, cp_m[1:0] & {2{stop_m == 0}});
      chk({cp1, cp0}, {cp_m[3], cp_m[2]});
   endtask
   task automatic model_clear();
      for (int p = 0; p < 3; p++) begin
         dir_m[p] = 0;
         out_m[p] = 0;
      end
      band_m = 0;
      cp_m = 0;
      stop_m = 0;
   endtask

   ////////////////////////////////////////
   initial begin
      seed = 32'hd5a2;
      {presetn, psel, penable, pwrite, wd, ce, stp} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      drv = '0;
      model_clear();
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      outs();
      rd(8'h2c, 32'h1);
      for (int i = 0; i < 6; i++) begin
         for (int p = 0; p < 3; p++) begin
            out_m[p] = $random(seed) & 15;
            dir_m[p] = $random(seed) & 15;
            drv[p] <= 4'($random(seed));
            apb(1'b1, 8'h08 + 8'(12 * p), out_m[p]);
            apb(1'b1, 8'h04 + 8'(12 * p), dir_m[p]);
         end
         dir_m[2] = dir_m[2][0] ? 15 : 0;
         outs();
         for (int p = 0; p < 3; p++) begin
            rd(8'h04 + 8'(12 * p), dir_m[p]);
            rd(8'h08 + 8'(12 * p), out_m[p]);
            rd(8'h0c + 8'(12 * p), (dir_m[p] & out_m[p]) | (~dir_m[p] & drv[p]));
         end
      end
      for (int b = 0; b < 4; b++) begin
         band_m = b;
         apb(1'b1, 8'h00, b);
         outs();
      end
      cp_m = ($random(seed) & 15) | 3;
      apb(1'b1, 8'h28, cp_m);
      outs();
      rd(8'h28, cp_m);
      stp <= 1'b1;
      stop_m = 1;
      outs();
      rd(8'h2c, 32'h9);
      stp <= 1'b0;
      stop_m = 0;
      ce <= 1'b1;
      repeat (5) @(posedge pclk);
      ce <= 1'b0;
      cp_m = 0;
      outs();
      rd(8'h28, 32'h0);
      rd(8'h2c, 32'h5);
      cp_m = 15;
      apb(1'b1, 8'h28, cp_m);
      wd <= 1'b1;
      @(posedge pclk);
      wd <= 1'b0;
      for (int p = 0; p < 3; p++)
         dir_m[p] = 0;
      band_m = 0;
      cp_m = 0;
      outs();
      rd(8'h2c, 32'h7);
      apb(1'b1, 8'h2c, 32'h6);
      rd(8'h2c, 32'h1);
      apb(1'b0, 8'h30, 32'h0);
      chk(32'(err), 32'h1);
      chk(r, 32'h0);
      presetn <= 1'b0;
      model_clear();
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      outs();
      rd(8'h2c, 32'h1);
      conclude();
   end
endmodule // io_port_pin_control_tb

`default_nettype wire
